// ===== dv/vpms_mac_model.sv
`timescale 1ns/10ps
module vpms_mac_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic rx_dv,
  input  wire logic send,
  output logic      tx_en,
  output int        rx_count
);
  // counts nibbles reaching the mac; stays flat while far loopback is on
  always_ff @(posedge clock) begin
    tx_en <= send;
    rx_count <= rst ? 0 : rx_count + int'(rx_dv);
  end
endmodule

// ===== dv/vpms_mode_status_assertions.sv
`timescale 1ns/10ps
module vpms_mode_status_assertions #(
  parameter int HOST_ADDR_W = 12
) (
  input wire logic                   CLOCK,
  input wire logic                   RST,
  input wire logic [HOST_ADDR_W-1:0] HOST_ADDR,
  input wire logic                   HOST_WR,
  input wire logic                   HOST_RD,
  input wire vpms_pkg::vpms_word_t   HOST_WDATA,
  input wire logic                   HOST_RD_VALID,
  input wire vpms_pkg::vpms_word_t   HOST_RDATA,
  input wire logic                   MII_WR,
  input wire logic                   AUTONEG_ENABLE,
  input wire logic                   SPEED_SELECT,
  input wire logic                   DUPLEX_SELECT,
  input wire vpms_pkg::vpms_speed_t  AUTONEG_RESULT,
  input wire logic                   VPHY_HARD_RESET,
  input wire logic                   VPHY_SOFT_RESET,
  input wire logic                   SW_TX_EN,
  input wire logic                   MAC_RX_DV,
  input wire logic                   LOOP_RX_DV,
  input wire logic                   MAC_TX_EN,
  input wire logic                   SW_COL,
  input wire logic                   HEARTBEAT_TEST_OFF
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_hit;
    HOST_RD && HOST_ADDR == 'h1dc;
  endsequence
  a_host_answer: assert property (HOST_RD |=> HOST_RD_VALID)
    else $error("host read got no valid");
  a_resv_zero: assert property (HOST_RD_VALID |-> (HOST_RDATA & 32'hffff_bf62) == 0)
    else $error("reserved bits not zero");
  a_speed_manual: assert property (s_hit ##0 !AUTONEG_ENABLE |=> HOST_RDATA[4:2] ==
    {$past(DUPLEX_SELECT), $past(SPEED_SELECT), !$past(SPEED_SELECT)})
    else $error("manual speed code wrong");
  a_speed_auto: assert property (s_hit ##0 AUTONEG_ENABLE |=>
    HOST_RDATA[4:2] == $past(AUTONEG_RESULT)) else $error("negotiated speed code wrong");
  a_bit0_write: assert property (HOST_WR && HOST_ADDR == 'h1dc && !VPHY_HARD_RESET
    && !VPHY_SOFT_RESET |=> HEARTBEAT_TEST_OFF == $past(HOST_WDATA[0]))
    else $error("heartbeat bit not written");
  a_soft_keep: assert property (VPHY_SOFT_RESET && !VPHY_HARD_RESET && !HOST_WR
    && !MII_WR |=> $stable(HEARTBEAT_TEST_OFF)) else $error("soft reset lost bit 0");
  a_loop_split: assert property (SW_TX_EN |=> MAC_RX_DV != LOOP_RX_DV)
    else $error("frame not steered to one side");
  a_col_idle: assert property (!MAC_TX_EN |=> !SW_COL)
    else $error("collision without transmit");
endmodule
bind vpms_mode_status vpms_mode_status_assertions #(
  .HOST_ADDR_W (HOST_ADDR_W)
) u_chk (
  .CLOCK              (CLOCK),
  .RST                (RST),
  .HOST_ADDR          (HOST_ADDR),
  .HOST_WR            (HOST_WR),
  .HOST_RD            (HOST_RD),
  .HOST_WDATA         (HOST_WDATA),
  .HOST_RD_VALID      (HOST_RD_VALID),
  .HOST_RDATA         (HOST_RDATA),
  .MII_WR             (MII_WR),
  .AUTONEG_ENABLE     (AUTONEG_ENABLE),
  .SPEED_SELECT       (SPEED_SELECT),
  .DUPLEX_SELECT      (DUPLEX_SELECT),
  .AUTONEG_RESULT     (AUTONEG_RESULT),
  .VPHY_HARD_RESET    (VPHY_HARD_RESET),
  .VPHY_SOFT_RESET    (VPHY_SOFT_RESET),
  .SW_TX_EN           (SW_TX_EN),
  .MAC_RX_DV          (MAC_RX_DV),
  .LOOP_RX_DV         (LOOP_RX_DV),
  .MAC_TX_EN          (MAC_TX_EN),
  .SW_COL             (SW_COL),
  .HEARTBEAT_TEST_OFF (HEARTBEAT_TEST_OFF)
);

// ===== dv/vpms_mode_status_tb.sv
`timescale 1ns/10ps
module vpms_mode_status_tb;
  import vpms_pkg::*;
  logic CLOCK = 0, RST = 1, HOST_WR = 0, HOST_RD = 0, MII_WR = 0, MII_RD = 0, mac_send = 0;
  logic AUTONEG_ENABLE = 0, SPEED_SELECT = 1, DUPLEX_SELECT = 1, SW_TX_EN = 0;
  logic VPHY_HARD_RESET = 0, VPHY_SOFT_RESET = 0, HEARTBEAT_DISABLE_STRAP = 1;
  logic [11:0] HOST_ADDR = 0;
  logic [4:0]  MII_INDEX = 0;
  logic [3:0]  SW_TXD = 0, MAC_RXD, LOOP_RXD;
  vpms_word_t  HOST_WDATA = 0, HOST_RDATA;
  vpms_half_t  MII_WDATA = 0, MII_RDATA;
  vpms_speed_t AUTONEG_RESULT = 0;
  vpms_speed_t codes [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
  logic HOST_RD_VALID, MII_RD_VALID, MAC_RX_DV, LOOP_RX_DV, MAC_TX_EN, SW_COL;
  logic HEARTBEAT_TEST_OFF;
  int n_mismatch = 0, check_count = 0, mac_rx_count;
  vpms_mode_status u_dut (
    .CLOCK                   (CLOCK),
    .RST                     (RST),
    .HOST_ADDR               (HOST_ADDR),
    .HOST_WR                 (HOST_WR),
    .HOST_RD                 (HOST_RD),
    .HOST_WDATA              (HOST_WDATA),
    .HOST_RD_VALID           (HOST_RD_VALID),
    .HOST_RDATA              (HOST_RDATA),
    .MII_INDEX               (MII_INDEX),
    .MII_WR                  (MII_WR),
    .MII_RD                  (MII_RD),
    .MII_WDATA               (MII_WDATA),
    .MII_RD_VALID            (MII_RD_VALID),
    .MII_RDATA               (MII_RDATA),
    .AUTONEG_ENABLE          (AUTONEG_ENABLE),
    .SPEED_SELECT            (SPEED_SELECT),
    .DUPLEX_SELECT           (DUPLEX_SELECT),
    .AUTONEG_RESULT          (AUTONEG_RESULT),
    .VPHY_HARD_RESET         (VPHY_HARD_RESET),
    .VPHY_SOFT_RESET         (VPHY_SOFT_RESET),
    .HEARTBEAT_DISABLE_STRAP (HEARTBEAT_DISABLE_STRAP),
    .SW_TX_EN                (SW_TX_EN),
    .SW_TXD                  (SW_TXD),
    .MAC_RX_DV               (MAC_RX_DV),
    .MAC_RXD                 (MAC_RXD),
    .LOOP_RX_DV              (LOOP_RX_DV),
    .LOOP_RXD                (LOOP_RXD),
    .MAC_TX_EN               (MAC_TX_EN),
    .SW_COL                  (SW_COL),
    .HEARTBEAT_TEST_OFF      (HEARTBEAT_TEST_OFF)
  );
  vpms_mac_model u_mac (.clock(CLOCK), .rst(RST), .rx_dv(MAC_RX_DV), .send(mac_send),
    .tx_en(MAC_TX_EN), .rx_count(mac_rx_count));
  always #2.5 CLOCK = ~CLOCK;
  task automatic step(int n = 1);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hw(logic [11:0] a, vpms_word_t d);
    HOST_ADDR = a;
    HOST_WDATA = d;
    HOST_WR = 1;
    step();
    HOST_WR = 0;
    step();
  endtask
  task automatic hr(logic [11:0] a, vpms_word_t e);
    HOST_ADDR = a;
    HOST_RD = 1;
    step();
    HOST_RD = 0;
    chk(HOST_RD_VALID, 1);
    chk(HOST_RDATA, e);
    step();
  endtask
  task automatic mr(logic [4:0] i, vpms_word_t e);
    MII_INDEX = i;
    MII_RD = 1;
    step();
    MII_RD = 0;
    chk(MII_RD_VALID, 1);
    chk(MII_RDATA, e);
    step();
  endtask
  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #2000;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    step(2);
    RST = 0;
    // strap synchroniser needs a few edges before bit 0 settles
    step(4);
    hr(12'h1dc, 32'h19);
    chk(HEARTBEAT_TEST_OFF, 1);
    hw(12'h1dc, 32'hffff_ffff);
    hr(12'h1dc, 32'h4099);
    mr(5'h1f, 32'h4099);
    mr(5'h1e, 0);
    hw(12'h1d8, 0);
    hr(12'h1d8, 0);
    hr(12'h1dc, 32'h4099);
    SW_TX_EN = 1;
    SW_TXD = 4'ha;
    mac_send = 1;
    step();
    chk({LOOP_RX_DV, LOOP_RXD, MAC_RX_DV}, 6'h34);
    step();
    chk(SW_COL, 1);
    SW_TX_EN = 0;
    mac_send = 0;
    chk(mac_rx_count, 0);
    MII_INDEX = 5'h1f;
    MII_WDATA = 16'h4080;
    MII_WR = 1;
    step();
    MII_WR = 0;
    mr(5'h1f, 32'h4098);
    chk(HEARTBEAT_TEST_OFF, 0);
    VPHY_SOFT_RESET = 1;
    step();
    VPHY_SOFT_RESET = 0;
    hr(12'h1dc, 32'h18);
    VPHY_HARD_RESET = 1;
    step();
    VPHY_HARD_RESET = 0;
    hr(12'h1dc, 32'h19);
    SW_TX_EN = 1;
    SW_TXD = 4'h5;
    mac_send = 1;
    step();
    chk({MAC_RX_DV, MAC_RXD, LOOP_RX_DV}, 6'h2a);
    SW_TX_EN = 0;
    mac_send = 0;
    step();
    chk(mac_rx_count, 1);
    chk(SW_COL, 0);
    for (int i = 0; i < 4; i++) begin
      AUTONEG_ENABLE = 0;
      {SPEED_SELECT, DUPLEX_SELECT} = 2'(i);
      hr(12'h1dc, {27'h0, codes[i], 2'h1});
      AUTONEG_ENABLE = 1;
      AUTONEG_RESULT = codes[3 - i];
      hr(12'h1dc, {27'h0, codes[3 - i], 2'h1});
    end
    // host and management write in one cycle: the host value must be kept
    MII_INDEX = 5'h1f;
    MII_WDATA = 16'h4080;
    MII_WR = 1;
    HOST_ADDR = 12'h1dc;
    HOST_WDATA = 32'h1;
    HOST_WR = 1;
    step();
    MII_WR = 0;
    HOST_WR = 0;
    hr(12'h1dc, 32'h5);
    // strap now low: a hard vphy reset must load the new level into bit 0
    HEARTBEAT_DISABLE_STRAP = 0;
    step(4);
    VPHY_HARD_RESET = 1;
    step();
    VPHY_HARD_RESET = 0;
    hr(12'h1dc, 32'h4);
    tally_and_finish();
  end
endmodule

// ===== shared/vpms_cfg.svh
// What this block does
// [R1] loopback bit 14 set: port-0 transmit frames go back into the switch, not the MAC
// [R2] collision-test bit 7 forces collision while the host mac transmits; it resets to zero
// [R3] bits 4:2 read speed/duplex: 001,010,101,110 are 10H,100H,10F,100F
// [R4] autoneg enabled: field shows negotiated result; else basic-control speed and duplex
// [R5] bit 0 heartbeat_test_off: zero enables heartbeat test, one disables it
// [R6] reset loads heartbeat_test_off from the sampled heartbeat_disable_strap level
// [R7] bit 0 restored by control or power resets, kept on emulated soft reset
// [R8] bits 31-16 pad host access; management access sees sixteen bits
// [R9] register decodes at host offset 1DCh and management index 31
// [R10] reserved bits read zero and ignore writes
// [R11] software should set collision test only while loopback is active
`ifndef VPMS_CFG_SVH
`define VPMS_CFG_SVH

`define VPMS_HOST_OFFSET 12'h1dc
`define VPMS_MII_INDEX   5'h1f
`define VPMS_LOOP_BIT    14
`define VPMS_COL_BIT     7
`define VPMS_SPD_HI      4
`define VPMS_SPD_LO      2
`define VPMS_HB_BIT      0
`define VPMS_LOOP_RST    1'b0
`define VPMS_COL_RST     1'b0
`define VPMS_SPD_10H     3'h1
`define VPMS_SPD_100H    3'h2
`define VPMS_SPD_10F     3'h5
`define VPMS_SPD_100F    3'h6
`define VPMS_SYNC_STAGES 3

`endif

// ===== shared/vpms_pkg.sv
package vpms_pkg;

  typedef logic [2:0]  vpms_speed_t;
  typedef logic [31:0] vpms_word_t;
  typedef logic [15:0] vpms_half_t;

  typedef struct packed {
    logic loopback;
    logic col_test;
    logic heartbeat_off;
  } vpms_ctrl_s;

endpackage

// ===== shared/vpms_sync_if.sv
`timescale 1ns/10ps
interface vpms_sync_if;
  logic strap_level;
  logic strap_primed;

  modport src (output strap_level, output strap_primed);
  modport dst (input strap_level, input strap_primed);
endinterface

// ===== verilog/vpms_mode_status.sv
`timescale 1ns/10ps
`include "vpms_cfg.svh"
module vpms_mode_status #(
  parameter int HOST_ADDR_W = 12,
  parameter int DATA_W      = 4
) (
  input  wire logic                    CLOCK,
  input  wire logic                    RST,
  // host register map, 32-bit word
  input  wire logic [HOST_ADDR_W-1:0]  HOST_ADDR,
  input  wire logic                    HOST_WR,
  input  wire logic                    HOST_RD,
  input  wire vpms_pkg::vpms_word_t    HOST_WDATA,
  output logic                         HOST_RD_VALID,
  output vpms_pkg::vpms_word_t         HOST_RDATA,
  // management access, 16-bit register
  input  wire logic [4:0]              MII_INDEX,
  input  wire logic                    MII_WR,
  input  wire logic                    MII_RD,
  input  wire vpms_pkg::vpms_half_t    MII_WDATA,
  output logic                         MII_RD_VALID,
  output vpms_pkg::vpms_half_t         MII_RDATA,
  // emulated phy control and negotiation state
  input  wire logic                    AUTONEG_ENABLE,
  input  wire logic                    SPEED_SELECT,
  input  wire logic                    DUPLEX_SELECT,
  input  wire vpms_pkg::vpms_speed_t   AUTONEG_RESULT,
  input  wire logic                    VPHY_HARD_RESET,
  input  wire logic                    VPHY_SOFT_RESET,
  input  wire logic                    HEARTBEAT_DISABLE_STRAP,
  // switch port 0 transmit toward the host mac
  input  wire logic                    SW_TX_EN,
  input  wire logic [DATA_W-1:0]       SW_TXD,
  output logic                         MAC_RX_DV,
  output logic [DATA_W-1:0]            MAC_RXD,
  output logic                         LOOP_RX_DV,
  output logic [DATA_W-1:0]            LOOP_RXD,
  // host mac transmit toward the switch engine
  input  wire logic                    MAC_TX_EN,
  output logic                         SW_COL,
  output logic                         HEARTBEAT_TEST_OFF
);
  import vpms_pkg::*;

  if (HOST_ADDR_W < 9) begin : g_addr_check
    $error("HOST_ADDR_W too narrow for the register offset");
  end
  if (DATA_W < 1) begin : g_data_check
    $error("DATA_W must be at least one");
  end

  vpms_sync_if strap_if ();

  vpms_strap_sync u_strap (
    .CLOCK     (CLOCK),
    .RST       (RST),
    .STRAP_PIN (HEARTBEAT_DISABLE_STRAP),
    .sync      (strap_if.src)
  );

  // code reported in bits 4:2 when negotiation is off
  function automatic vpms_speed_t manual_code(input logic spd100, input logic full);
    vpms_speed_t c;
    c = `VPMS_SPD_10H;
    case ({full, spd100})
      2'b00:   c = `VPMS_SPD_10H;
      2'b01:   c = `VPMS_SPD_100H;
      2'b10:   c = `VPMS_SPD_10F;
      2'b11:   c = `VPMS_SPD_100F;
      default: c = `VPMS_SPD_10H;
    endcase
    return c;
  endfunction

  // the sixteen-bit image, shared by both access paths; only bits 14, 7, 4:2 and 0 are live, all others are zero
  function automatic vpms_half_t pack_reg(input vpms_ctrl_s ctl, input vpms_speed_t spd);
    vpms_half_t r;
    r                             = 16'h0000; // R10
    r[`VPMS_LOOP_BIT]             = ctl.loopback;
    r[`VPMS_COL_BIT]              = ctl.col_test;
    r[`VPMS_SPD_HI:`VPMS_SPD_LO]  = spd; // R3
    r[`VPMS_HB_BIT]               = ctl.heartbeat_off; // R5
    return r;
  endfunction

  vpms_ctrl_s  ctrl_q;
  vpms_ctrl_s  ctrl_d;
  vpms_speed_t speed_code;
  logic        host_hit;
  logic        mii_hit;
  logic        wr_en;
  vpms_half_t  wr_val;
  logic        strap_pend_q;
  logic        strap_pend_d;

  assign host_hit = (HOST_ADDR == HOST_ADDR_W'(`VPMS_HOST_OFFSET)); // R9
  assign mii_hit  = (MII_INDEX == `VPMS_MII_INDEX); // R9

  always_comb begin
    if (AUTONEG_ENABLE) begin
      speed_code = AUTONEG_RESULT; // R4
    end else begin
      speed_code = manual_code(SPEED_SELECT, DUPLEX_SELECT); // R4
    end
  end

  // host wins when both paths write in the same cycle; upper host bits are padding
  always_comb begin
    wr_en  = 1'b0;
    wr_val = 16'h0000;
    if (HOST_WR && host_hit) begin
      wr_en  = 1'b1;
      wr_val = HOST_WDATA[15:0]; // R8
    end else if (MII_WR && mii_hit) begin
      wr_en  = 1'b1;
      wr_val = MII_WDATA;
    end
  end

  // control bits: chip and hard vphy resets restore the strap default, soft reset keeps it
  always_comb begin
    ctrl_d       = ctrl_q;
    strap_pend_d = strap_pend_q;
    if (RST || VPHY_HARD_RESET) begin
      ctrl_d.loopback = `VPMS_LOOP_RST;
      ctrl_d.col_test = `VPMS_COL_RST; // R2
      strap_pend_d    = 1'b1;
      if (strap_if.strap_primed) begin
        ctrl_d.heartbeat_off = strap_if.strap_level; // R6 R7
        strap_pend_d         = 1'b0;
      end
    end else if (VPHY_SOFT_RESET) begin
      ctrl_d.loopback = `VPMS_LOOP_RST;
      ctrl_d.col_test = `VPMS_COL_RST; // R7
    end else begin
      if (strap_pend_q && strap_if.strap_primed) begin
        ctrl_d.heartbeat_off = strap_if.strap_level; // R6
        strap_pend_d         = 1'b0;
      end
      if (wr_en) begin
        ctrl_d.loopback      = wr_val[`VPMS_LOOP_BIT]; // R1
        ctrl_d.col_test      = wr_val[`VPMS_COL_BIT]; // R2
        ctrl_d.heartbeat_off = wr_val[`VPMS_HB_BIT]; // R5
        strap_pend_d         = 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    ctrl_q       <= ctrl_d;
    strap_pend_q <= strap_pend_d;
  end

  // read answers: one cycle after the request, data from flip-flops
  logic       host_vld_d;
  vpms_word_t host_dat_d;
  logic       mii_vld_d;
  vpms_half_t mii_dat_d;

  always_comb begin
    host_vld_d = 1'b0;
    host_dat_d = 32'h0000_0000;
    mii_vld_d  = 1'b0;
    mii_dat_d  = 16'h0000;
    if (!RST && HOST_RD) begin
      host_vld_d = 1'b1;
      if (host_hit) begin
        host_dat_d = {16'h0000, pack_reg(ctrl_q, speed_code)}; // R8
      end
    end
    if (!RST && MII_RD) begin
      mii_vld_d = 1'b1;
      if (mii_hit) begin
        mii_dat_d = pack_reg(ctrl_q, speed_code); // R8
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    HOST_RD_VALID <= host_vld_d;
    HOST_RDATA    <= host_dat_d;
    MII_RD_VALID  <= mii_vld_d;
    MII_RDATA     <= mii_dat_d;
  end

  // datapath steering; toggling loopback mid-frame splits that frame, software
  // should change it between frames
  logic              mac_dv_d;
  logic [DATA_W-1:0] mac_d_d;
  logic              loop_dv_d;
  logic [DATA_W-1:0] loop_d_d;
  logic              col_d;

  always_comb begin
    mac_dv_d  = 1'b0;
    mac_d_d   = '0;
    loop_dv_d = 1'b0;
    loop_d_d  = '0;
    col_d     = 1'b0;
    if (!RST) begin
      if (ctrl_q.loopback) begin
        loop_dv_d = SW_TX_EN; // R1
        loop_d_d  = SW_TXD; // R1
      end else begin
        mac_dv_d = SW_TX_EN;
        mac_d_d  = SW_TXD;
      end
      // forced collision is only sensible with loopback on, but is not gated by it
      col_d = ctrl_q.col_test && MAC_TX_EN; // R2 R11
    end
  end

  always_ff @(posedge CLOCK) begin
    MAC_RX_DV  <= mac_dv_d;
    MAC_RXD    <= mac_d_d;
    LOOP_RX_DV <= loop_dv_d;
    LOOP_RXD   <= loop_d_d;
    SW_COL     <= col_d;
  end

  assign HEARTBEAT_TEST_OFF = ctrl_q.heartbeat_off; // R5
endmodule

// ===== verilog/vpms_strap_sync.sv
`timescale 1ns/10ps
`include "vpms_cfg.svh"
module vpms_strap_sync (
  input  wire logic  CLOCK,
  input  wire logic  RST,
  input  wire logic  STRAP_PIN,
  vpms_sync_if.src   sync
);
  import vpms_pkg::*;

  logic [`VPMS_SYNC_STAGES-1:0] chain_q;
  logic [`VPMS_SYNC_STAGES-1:0] chain_d;
  logic                         level_q;
  logic                         level_d;
  logic [1:0]                   fill_q;
  logic [1:0]                   fill_d;

  // chain shifts under reset too; priming waits three edges past reset so that
  // every stage holds the pin before its level is trusted
  always_comb begin
    chain_d = {chain_q[`VPMS_SYNC_STAGES-2:0], STRAP_PIN};
    level_d = level_q;
    fill_d  = fill_q;
    if (RST) begin
      fill_d = 2'h0;
    end else if (fill_q != 2'h3) begin
      fill_d = fill_q + 2'h1;
    end
    if (chain_q[1] == chain_q[2]) begin
      level_d = chain_q[2];
    end
  end

  always_ff @(posedge CLOCK) begin
    chain_q <= chain_d;
    level_q <= level_d;
    fill_q  <= fill_d;
  end

  assign sync.strap_level  = level_q;
  assign sync.strap_primed = (fill_q == 2'h3);
endmodule
